// File: common/dmem_pkg.sv
// Purpose: Shared constants for the data memory space decoder
// Assumes: 8-bit data, 16-bit external data addresses
// Notes:   Nothing is imported; use dmem_pkg::name
package dmem_pkg;
	localparam int          DATA_W          = 8;
	localparam int          XADDR_W         = 16;
	localparam int          AUX_RAM_SMALL   = 256;
	localparam int          AUX_RAM_LARGE   = 768;
	localparam logic [7:0]  LOWER_RAM_TOP   = 8'h7f;
	localparam logic [7:0]  AUX_CTRL_RESET  = 8'h00;
	localparam int          AUX_DISABLE_BIT = 1;
	localparam logic [7:0]  PORT_TWO_RESET  = 8'hff;
	localparam logic [7:0]  PORT_ZERO_RESET = 8'hff;
	localparam int          BUS_PHASES      = 3;

	// Where the internal access lands
	typedef enum logic [1:0] {
		TGT_RAM,
		TGT_SFS
	} int_target_type;
endpackage

// File: hw/byte_ram.sv
// Purpose: Single-port synchronous byte RAM
// Assumes: Write and read in the same cycle return old data
// Notes:   Read data registered
module byte_ram #(
	parameter int DEPTH  = 256,
	parameter int ADDR_W = 8
) (
	input  wire logic                clk_sys,
	input  wire logic                en,
	input  wire logic                we,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [7:0]          wdata,
	output logic      [7:0]          rdata
);
	logic [7:0] mem [DEPTH];

	// Refuse a depth the address cannot reach
	if (DEPTH > (1 << ADDR_W)) begin : g_bad_depth
		$error("byte_ram depth exceeds address range");
	end

	// Array itself has no reset; contents are undefined after power-up
	always_ff @(posedge clk_sys) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule // byte_ram

// File: hw/data_memory_space_decoder.sv
// Purpose: Decodes CPU data accesses to lower/upper RAM, special function space,
//          on-chip expanded RAM, or the multiplexed external bus
// Assumes: One request at a time; CPU waits for done
// Notes:   Port zero is driven as an output value with an active-low enable; port two has no enable
//
// What this block does
// - Lower RAM 00h-7fh is reached the same way by direct and indirect accesses.
// - Upper RAM 80h-ffh is reachable only through indirect accesses.
// - A direct access above 7fh goes to special function space.
// - An indirect access above 7fh goes to the upper half of the one internal RAM array that also holds lower RAM.
// - Expanded RAM of 256 or 768 bytes is reached by external moves only while the disable bit is clear.
// - With the bit clear, index-register moves and pointer moves below the on-chip size target expanded RAM.
// - An expanded RAM hit leaves port zero and both strobes untouched.
// - During expanded RAM access port two keeps driving its own register value.
// - With the bit clear, pointer moves above the on-chip range run a normal bus cycle.
// - Expanded RAM sits at the lowest external addresses, so index access to a0h stays on chip.
// - With the bit set, index moves put an 8-bit address on port zero, upper bits left to software.
// - With the bit set, pointer moves drive the high byte on port two and low byte on port zero.
// - Bus cycles pulse the write strobe for writes and the read strobe for reads.
module data_memory_space_decoder #(
	parameter int AUX_RAM_BYTES = dmem_pkg::AUX_RAM_SMALL
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Internal data access
	input  wire logic        int_req,
	input  wire logic        int_indirect,
	input  wire logic        int_we,
	input  wire logic [7:0]  int_addr,
	input  wire logic [7:0]  int_wdata,
	output logic      [7:0]  int_rdata,
	output logic             int_done,
	// Special function space hand-off
	output logic             sfs_req,
	output logic             sfs_we,
	output logic      [7:0]  sfs_addr,
	output logic      [7:0]  sfs_wdata,
	input  wire logic [7:0]  sfs_rdata,
	// External move
	input  wire logic        xm_req,
	input  wire logic        xm_use_pointer,
	input  wire logic        xm_we,
	input  wire logic [7:0]  index_value,
	input  wire logic [7:0]  data_pointer_high,
	input  wire logic [7:0]  data_pointer_low,
	input  wire logic [7:0]  xm_wdata,
	output logic      [7:0]  xm_rdata,
	output logic             xm_done,
	// Control register write, readback and port register values
	input  wire logic        aux_wr,
	input  wire logic [7:0]  aux_wdata,
	output logic      [7:0]  auxiliary_control_reg,
	input  wire logic [7:0]  port_two_sfr,
	input  wire logic [7:0]  port_zero_sfr,
	// Pins
	output logic      [7:0]  port_zero_out,
	output logic             port_zero_oe_n,
	input  wire logic [7:0]  port_zero_in,
	output logic      [7:0]  port_two_out,
	output logic             wr_strobe_n,
	output logic             rd_strobe_n
);
	localparam int XR_AW = $clog2(AUX_RAM_BYTES);

	// Only the two array sizes have a decode boundary worked out
	if (AUX_RAM_BYTES != dmem_pkg::AUX_RAM_SMALL &&
	    AUX_RAM_BYTES != dmem_pkg::AUX_RAM_LARGE) begin : g_bad_size
		$error("AUX_RAM_BYTES must be 256 or 768");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INT,
		ST_XRAM,
		ST_BUS,
		ST_DONE
	} state_type;

	state_type              state_r, state_nxt;
	dmem_pkg::int_target_type tgt_r, tgt_nxt;
	logic [1:0]             phase_r, phase_nxt;
	logic [7:0]             aux_r, aux_nxt;
	logic [7:0]             p0_r, p0_nxt;
	logic                   p0_oe_n_r, p0_oe_n_nxt;
	logic [7:0]             p2_r, p2_nxt;
	logic                   addr_hold_r, addr_hold_nxt;
	logic                   wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt;
	logic [7:0]             xrd_r, xrd_nxt;
	logic                   bwe_r, bwe_nxt;
	logic [7:0]             bwd_r, bwd_nxt;
	logic [7:0]             p0_s1, p0_s2;
	logic                   aux_dis;
	logic [15:0]            xaddr;
	logic                   xram_hit;
	logic                   iram_en, xram_en;
	logic [7:0]             iram_q, xram_q;

	assign aux_dis = aux_r[dmem_pkg::AUX_DISABLE_BIT];
	// Index moves carry only 8 bits; upper address is zero for the on-chip compare
	assign xaddr = xm_use_pointer ? {data_pointer_high, data_pointer_low}
	                              : {8'h00, index_value};
	// On-chip range occupies the lowest external addresses
	assign xram_hit = !aux_dis && (xaddr < 16'(AUX_RAM_BYTES));

	// One array holds lower and upper RAM; direct access never reaches upper half
	assign iram_en = (state_r == ST_IDLE) && int_req &&
	                 (int_indirect || int_addr <= dmem_pkg::LOWER_RAM_TOP);
	assign xram_en = (state_r == ST_IDLE) && !int_req && xm_req && xram_hit;

	byte_ram #(.DEPTH(256), .ADDR_W(8)) u_iram (
		.clk_sys (clk_sys),
		.en      (iram_en),
		.we      (int_we),
		.addr    (int_addr),
		.wdata   (int_wdata),
		.rdata   (iram_q)
	);

	byte_ram #(.DEPTH(AUX_RAM_BYTES), .ADDR_W(XR_AW)) u_xram (
		.clk_sys (clk_sys),
		.en      (xram_en),
		.we      (xm_we),
		.addr    (xaddr[XR_AW-1:0]),
		.wdata   (xm_wdata),
		.rdata   (xram_q)
	);

	// Direct access above lower RAM is handed to special function space
	assign sfs_req   = (state_r == ST_IDLE) && int_req && !int_indirect &&
	                   (int_addr > dmem_pkg::LOWER_RAM_TOP);
	assign sfs_we    = int_we;
	assign sfs_addr  = int_addr;
	assign sfs_wdata = int_wdata;

	assign int_done  = (state_r == ST_INT);
	assign int_rdata = (tgt_r == dmem_pkg::TGT_SFS) ? sfs_rdata : iram_q;
	assign xm_done   = (state_r == ST_DONE);
	assign xm_rdata  = xrd_r;

	assign auxiliary_control_reg = aux_r;
	assign port_zero_out  = p0_r;
	assign port_zero_oe_n = p0_oe_n_r;
	// Port two shows its own register unless a pointer bus cycle owns it
	assign port_two_out   = addr_hold_r ? p2_r : port_two_sfr;
	assign wr_strobe_n    = wr_n_r;
	assign rd_strobe_n    = rd_n_r;

	// Port zero read data is a pin input and is synchronised first
	always_ff @(posedge clk_sys) begin
		p0_s1 <= port_zero_in;
		p0_s2 <= p0_s1;
	end

	// Next-state logic; internal requests win over external moves
	always_comb begin
		state_nxt     = state_r;
		tgt_nxt       = tgt_r;
		phase_nxt     = phase_r;
		aux_nxt       = aux_r;
		p0_nxt        = p0_r;
		p0_oe_n_nxt   = p0_oe_n_r;
		p2_nxt        = p2_r;
		addr_hold_nxt = addr_hold_r;
		wr_n_nxt      = wr_n_r;
		rd_n_nxt      = rd_n_r;
		xrd_nxt       = xrd_r;
		bwe_nxt       = bwe_r;
		bwd_nxt       = bwd_r;
		if (aux_wr) begin
			aux_nxt = aux_wdata;
		end
		unique case (state_r)
			ST_IDLE: begin
				if (int_req) begin
					tgt_nxt   = sfs_req ? dmem_pkg::TGT_SFS : dmem_pkg::TGT_RAM;
					state_nxt = ST_INT;
				end else if (xm_req && xram_hit) begin
					// Pins stay as they are for an on-chip hit
					state_nxt = ST_XRAM;
				end else if (xm_req) begin
					// Address phase: low byte on port zero, strobes idle
					p0_nxt        = xaddr[7:0];
					p0_oe_n_nxt   = 1'b0;
					addr_hold_nxt = xm_use_pointer;
					p2_nxt        = data_pointer_high;
					bwe_nxt       = xm_we;
					bwd_nxt       = xm_wdata;
					phase_nxt     = 2'd0;
					state_nxt     = ST_BUS;
				end
			end
			ST_INT: begin
				state_nxt = ST_IDLE;
			end
			ST_XRAM: begin
				xrd_nxt   = xram_q;
				state_nxt = ST_DONE;
			end
			ST_BUS: begin
				phase_nxt = phase_r + 2'd1;
				if (phase_r == 2'd0) begin
					// Data phase: drive write data or release port zero
					p0_nxt      = bwe_r ? bwd_r : dmem_pkg::PORT_ZERO_RESET;
					p0_oe_n_nxt = !bwe_r;
					wr_n_nxt    = !bwe_r;
					rd_n_nxt    = bwe_r;
				end else if (phase_r == 2'(dmem_pkg::BUS_PHASES)) begin
					// Pin data has crossed both synchroniser stages only by now
					if (!bwe_r) begin
						xrd_nxt = p0_s2;
					end
					wr_n_nxt      = 1'b1;
					rd_n_nxt      = 1'b1;
					p0_nxt        = port_zero_sfr;
					p0_oe_n_nxt   = 1'b1;
					addr_hold_nxt = 1'b0;
					state_nxt     = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Registers only; synchronous reset
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r     <= ST_IDLE;
			tgt_r       <= dmem_pkg::TGT_RAM;
			phase_r     <= 2'd0;
			aux_r       <= dmem_pkg::AUX_CTRL_RESET;
			p0_r        <= dmem_pkg::PORT_ZERO_RESET;
			p0_oe_n_r   <= 1'b1;
			p2_r        <= dmem_pkg::PORT_TWO_RESET;
			addr_hold_r <= 1'b0;
			wr_n_r      <= 1'b1;
			rd_n_r      <= 1'b1;
			xrd_r       <= 8'h00;
			bwe_r       <= 1'b0;
			bwd_r       <= 8'h00;
		end else begin
			state_r     <= state_nxt;
			tgt_r       <= tgt_nxt;
			phase_r     <= phase_nxt;
			aux_r       <= aux_nxt;
			p0_r        <= p0_nxt;
			p0_oe_n_r   <= p0_oe_n_nxt;
			p2_r        <= p2_nxt;
			addr_hold_r <= addr_hold_nxt;
			wr_n_r      <= wr_n_nxt;
			rd_n_r      <= rd_n_nxt;
			xrd_r       <= xrd_nxt;
			bwe_r       <= bwe_nxt;
			bwd_r       <= bwd_nxt;
		end
	end
endmodule // data_memory_space_decoder

// File: tb/dmem_props.sv
// Purpose: Port checker for the data memory space decoder
// Assumes: One request at a time, bench holds request fields until done
// Notes:   Bound from the bench top
module dmem_props #(
	parameter int AUX_RAM_BYTES = 256
) (
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic       int_req,
	input wire logic       int_indirect,
	input wire logic       int_done,
	input wire logic       sfs_req,
	input wire logic       xm_req,
	input wire logic       xm_use_pointer,
	input wire logic       xm_we,
	input wire logic       xm_done,
	input wire logic       port_zero_oe_n,
	input wire logic       wr_strobe_n,
	input wire logic       rd_strobe_n,
	input wire logic [7:0] int_addr,
	input wire logic [7:0] index_value,
	input wire logic [7:0] data_pointer_high,
	input wire logic [7:0] data_pointer_low,
	input wire logic [7:0] auxiliary_control_reg,
	input wire logic [7:0] port_two_sfr,
	input wire logic [7:0] port_zero_out,
	input wire logic [7:0] port_two_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus cycle due: disable bit set, or pointer past the on-chip size
	logic bus;
	assign bus = auxiliary_control_reg[dmem_pkg::AUX_DISABLE_BIT] ||
		xm_use_pointer && {data_pointer_high, data_pointer_low} >= AUX_RAM_BYTES;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_sfs; sfs_req |-> int_req && !int_indirect && int_addr[7]; endproperty
	a_sfs: assert property (p_sfs) else $error("sfs_req off");
	property p_idone; $rose(int_req) |=> int_done; endproperty
	a_idone: assert property (p_idone) else $error("int_done late");
	property p_quiet; xm_req && !bus |-> wr_strobe_n && rd_strobe_n && port_zero_oe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("pins moved on chip");
	property p_xon; $rose(xm_req) && !bus |-> ##2 xm_done; endproperty
	a_xon: assert property (p_xon) else $error("on chip move late");
	property p_xbus; $rose(xm_req) && bus |=> !port_zero_oe_n ##4 xm_done; endproperty
	a_xbus: assert property (p_xbus) else $error("bus cycle wrong");
	property p_p2;
		port_two_out == port_two_sfr || xm_use_pointer && bus && port_two_out == data_pointer_high;
	endproperty
	a_p2: assert property (p_p2) else $error("port two wrong");
	property p_adr; !port_zero_oe_n && wr_strobe_n && rd_strobe_n |->
		port_zero_out == (xm_use_pointer ? data_pointer_low : index_value); endproperty
	a_adr: assert property (p_adr) else $error("address byte wrong");
	property p_strb; !(wr_strobe_n && rd_strobe_n) |-> xm_req && bus &&
		xm_we == !wr_strobe_n && (wr_strobe_n || rd_strobe_n); endproperty
	a_strb: assert property (p_strb) else $error("strobe wrong");
endmodule // dmem_props

// File: tb/xbus_memory.sv
// Purpose: External data memory on the multiplexed bus pins
// Assumes: Address phase has port zero driven and both strobes high
// Notes:   Released port zero shows the inverse so stale data never passes
module xbus_memory (
	input  wire logic [7:0] port_zero_out,
	input  wire logic [7:0] port_two_out,
	input  wire logic       clk_sys,
	input  wire logic       port_zero_oe_n,
	input  wire logic       wr_strobe_n,
	input  wire logic       rd_strobe_n,
	output logic      [7:0] port_zero_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:65535];
	logic [15:0] adr = 16'h0000;
	initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
	// Latch the address, store while the write strobe is low
	always @(posedge clk_sys) begin
		if (!port_zero_oe_n && wr_strobe_n && rd_strobe_n)
			adr <= {port_two_out, port_zero_out};
		if (!wr_strobe_n)
			mem[adr] <= port_zero_out;
	end
	// Pin level from both drivers
	assign port_zero_in = !port_zero_oe_n ? port_zero_out : !rd_strobe_n ? mem[adr] : ~mem[adr];
endmodule // xbus_memory

// File: tb/data_memory_space_decoder_tb_top.sv
// Purpose: Self-checking bench for the data memory space decoder
// Assumes: Partner memory on the bus pins, swapped address as special space data
// Notes:   Expanded RAM built at its larger size
module data_memory_space_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int XB = dmem_pkg::AUX_RAM_LARGE;
	logic       clk_sys = 0, resetn = 0, int_req = 0, int_indirect = 0, int_we = 0;
	logic       xm_req = 0, xm_use_pointer = 0, xm_we = 0, aux_wr = 0, mb;
	logic       int_done, sfs_req, sfs_we, xm_done, port_zero_oe_n, wr_strobe_n, rd_strobe_n;
	logic [7:0] int_addr = 0, int_wdata = 0, index_value = 0, data_pointer_high = 0;
	logic [7:0] data_pointer_low = 0, xm_wdata = 0, aux_wdata = 0, port_two_sfr = 0;
	logic [7:0] port_zero_sfr = 0, sfs_rdata, port_zero_in, int_rdata, sfs_addr, sfs_wdata;
	logic [7:0] xm_rdata, auxiliary_control_reg, port_zero_out, port_two_out, q, d, a, keep;
	logic [15:0] xa;
	logic [7:0] sfs_last = 8'h00;
	logic [31:0] rnd = 32'he3eb;
	int         n_errors = 0, n_tests = 0;

	always #5 clk_sys = ~clk_sys;
	// Special space answers with the nibble-swapped address
	assign sfs_rdata = {sfs_addr[3:0], sfs_addr[7:4]};
	// Special space keeps the last byte written to it
	always @(posedge clk_sys)
		if (sfs_req && sfs_we)
			sfs_last <= sfs_wdata;

	data_memory_space_decoder #(.AUX_RAM_BYTES(XB)) u_dut (.clk_sys, .resetn, .int_req,
		.int_indirect, .int_we, .int_addr, .int_wdata, .int_rdata, .int_done, .sfs_req,
		.sfs_we, .sfs_addr, .sfs_wdata, .sfs_rdata, .xm_req, .xm_use_pointer, .xm_we,
		.index_value, .data_pointer_high, .data_pointer_low, .xm_wdata, .xm_rdata, .xm_done,
		.aux_wr, .aux_wdata, .auxiliary_control_reg, .port_two_sfr, .port_zero_sfr,
		.port_zero_out, .port_zero_oe_n, .port_zero_in, .port_two_out, .wr_strobe_n,
		.rd_strobe_n);
	xbus_memory u_mem (.clk_sys, .port_zero_out, .port_zero_oe_n, .port_two_out,
		.wr_strobe_n, .rd_strobe_n, .port_zero_in);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Lower bytes keep the last write; upper ones split by addressing mode
	function automatic logic [7:0] exp_rd(input logic ind, input logic [7:0] ad, dv);
		return !ad[7] ? ~dv : ind ? dv : {ad[3:0], ad[7:4]};
	endfunction
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One request, held until done and dropped in the done cycle
	task automatic acc(input logic x, md, we, input logic [15:0] ad, input logic [7:0] wd);
		int k;
		int_indirect = md;
		xm_use_pointer = md;
		int_we = we;
		xm_we = we;
		int_addr = ad[7:0];
		index_value = ad[7:0];
		data_pointer_low = ad[7:0];
		data_pointer_high = ad[15:8];
		int_wdata = wd;
		xm_wdata = wd;
		int_req = !x;
		xm_req = x;
		for (k = 0; k < 20 && (x ? xm_done : int_done) !== 1'b1; k++)
			tick();
		if (k == 20)
			n_errors++;
		q = x ? xm_rdata : int_rdata;
		int_req = 0;
		xm_req = 0;
		tick();
	endtask
	task automatic set_aux(input logic [7:0] v);
		aux_wdata = v;
		aux_wr = 1;
		tick();
		aux_wr = 0;
		tick();
		chk("aux", auxiliary_control_reg, v);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (10) tick();
		resetn = 1;
		tick();
		chk("aux reset", auxiliary_control_reg, dmem_pkg::AUX_CTRL_RESET);
		chk("idle pins", {5'h00, wr_strobe_n, rd_strobe_n, port_zero_oe_n}, 8'h07);
		// Corners 00 7f ff 80 first, then random; stack-like traffic stays internal
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			a = i < 4 ? {i[1], {7{i[0] ^ i[1]}}} : rnd[7:0];
			d = rnd[15:8];
			port_zero_sfr = rnd[31:24];
			acc(0, 1, 1, {8'h00, a}, d);
			acc(0, 0, 1, {8'h00, a}, ~d);
			if (a[7])
				chk("sfs wr", sfs_last, ~d);
			for (int r = 0; r < 2; r++) begin
				acc(0, r[0], 0, {8'h00, a}, 8'h00);
				chk("int rd", q, exp_rd(r[0], a, d));
			end
		end
		$display("internal test done");
		// Index write and pointer read meet only where both reach the same store
		for (int m = 0; m < 2; m++) begin
			mb = m[0];
			set_aux(8'(mb) << dmem_pkg::AUX_DISABLE_BIT);
			for (int i = 0; i < 6; i++) begin
				rnd = lfsr(rnd);
				xa = i == 0 ? 16'h00a0 : i == 1 ? 16'(XB - 1) : i == 2 ? 16'(XB) : rnd[15:0];
				d = rnd[23:16];
				port_two_sfr = xa[15:8];
				acc(1, !(mb || xa < 16'h0100), 1, xa, d);
				if (m == 0 && i == 0)
					keep = d;
				port_two_sfr = ~xa[15:8];
				acc(1, 1, 0, xa, 8'h00);
				chk("xm rd", q, d);
			end
			$display("external move test %0d done", m);
		end
		// Mid-run reset must clear the disable bit left set above
		resetn = 0;
		repeat (2) tick();
		resetn = 1;
		tick();
		chk("aux mid reset", auxiliary_control_reg, dmem_pkg::AUX_CTRL_RESET);
		set_aux(8'h00);
		acc(1, 1, 0, 16'h00a0, 8'h00);
		chk("xram kept", q, keep);
		$display("expanded ram retention test done");
		report_and_stop();
	end
endmodule // data_memory_space_decoder_tb_top

bind data_memory_space_decoder dmem_props #(.AUX_RAM_BYTES(AUX_RAM_BYTES)) u_props (.clk_sys,
	.resetn, .int_req, .int_indirect, .int_done, .sfs_req, .xm_req, .xm_use_pointer, .xm_we,
	.xm_done, .port_zero_oe_n, .wr_strobe_n, .rd_strobe_n, .int_addr, .index_value,
	.data_pointer_high, .data_pointer_low, .auxiliary_control_reg, .port_two_sfr,
	.port_zero_out, .port_two_out);
